// ### mla_pkg.sv
`default_nettype none
package mla_pkg;

    // Block geometry
    localparam int N_MC = 16;
    localparam int CHAIN_LEN = 8;
    localparam int N_DED = 4;
    localparam int N_PT = 5;
    localparam int N_PIA = 36;
    localparam int N_IO = 16;
    localparam int N_EXT = 16;
    localparam int ARR_W = N_PIA + N_MC;
    localparam int MAX_SETS = 3;
    localparam int N_GCLK = 2;
    localparam int DELAY_W = 8;

    // Interconnect source numbering
    localparam int SRC_W = 6;
    localparam int SRC_DED = 0;
    localparam int SRC_IO = SRC_DED + N_DED;
    localparam int SRC_LOC = SRC_IO + N_IO;
    localparam int SRC_EXT = SRC_LOC + N_MC;
    localparam int SRC_END = SRC_EXT + N_EXT;
    localparam int SRC_PAD = (2 ** SRC_W) - SRC_END;

    // Dedicated input roles
    localparam int DED_GCLK_A = 0;
    localparam int DED_GCLR_LOW = 1;
    localparam int DED_OE_A = 2;
    localparam int DED_GCLK_B = 3;

    // Register map (byte offsets)
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_IO_SW = 8'h04;
    localparam logic [7:0] OFF_MC_OUT = 8'h08;
    localparam logic [7:0] OFF_DED_IN = 8'h0C;
    localparam int CTRL_IO_SW_SEL_BIT = 0;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [N_IO-1:0] IO_SW_RST = 16'h0000;
    localparam logic [N_MC-1:0] MC_RST = 16'h0000;

    // Delay weights in ns
    localparam int SEXP_DELAY_NS_DEF = 1;
    localparam int PEXP_DELAY_NS_DEF = 1;

    typedef enum logic [3:0] {
        PT_OFF  = 4'h0,
        PT_OR   = 4'h1,
        PT_CLR  = 4'h2,
        PT_PRS  = 4'h3,
        PT_CLK  = 4'h4,
        PT_ENA  = 4'h5,
        PT_AUX  = 4'h6,
        PT_SHR  = 4'h7,
        PT_LEND = 4'h8
    } mla_pt_route_t;

    typedef enum logic [1:0] {
        FF_D  = 2'h0,
        FF_T  = 2'h1,
        FF_JK = 2'h2,
        FF_SR = 2'h3
    } mla_ff_type_t;

    typedef enum logic [1:0] {
        CLK_GLOBAL     = 2'h0,
        CLK_GLOBAL_ENA = 2'h1,
        CLK_ARRAY      = 2'h2
    } mla_clk_mode_t;

    typedef struct packed {
        logic [ARR_W-1:0] use_true;
        logic [ARR_W-1:0] use_comp;
        mla_pt_route_t route;
    } mla_pt_cfg_t;

    typedef struct packed {
        mla_pt_cfg_t [N_PT-1:0] pt;
        logic xor_inv;
        mla_ff_type_t ff_type;
        mla_clk_mode_t clk_mode;
        logic gclk_sel;
        logic gclr_en;
        logic fast_in_en;
        logic bypass;
        logic [1:0] borrow_sets;
    } mla_mc_cfg_t;

    typedef struct packed {
        logic pass;
        logic [SRC_W-1:0] src;
    } mla_pia_cfg_t;

    typedef struct packed {
        logic pin_b_sel;
        logic invert;
    } mla_gclk_cfg_t;

endpackage : mla_pkg
`default_nettype wire

// ### mla_logic_array_block.sv
// Function
// - Four dedicated inputs: general or global control
// - Block holds exactly sixteen macrocells
// - Thirty-six interconnect inputs plus global controls
// - Five product terms; combinatorial or registered
// - Select matrix routes terms to logic/controls
// - Sixteen inverted shareable expanders shared blockwide
// - Register acts D, T, JK, SR or bypassed
// - Global, gated global, or array clock modes
// - Two selectable true/inverted global clocks
// - Product-term preset and clear, active high
// - Per-register clear from global clear pin
// - Registers power up low
// - Fast path from pin to D input
// - Up to fifteen borrowed terms, three sets
// - Each set and shareable use adds delay
// - Two chains; borrow from lower neighbours only
// - Chain bottom only lends, top only borrows
// - Interconnect fed by all sources, any-to-any
// - Each interconnect input gated by AND bit
// - Fixed equal interconnect delay, no skew
//
// Decided for this implementation: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module mla_logic_array_block #(
    parameter bit ENHANCED = 1'b1,
    parameter int SEXP_DELAY_NS = mla_pkg::SEXP_DELAY_NS_DEF,
    parameter int PEXP_DELAY_NS = mla_pkg::PEXP_DELAY_NS_DEF
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [mla_pkg::N_DED-1:0] ded_pin,
    input wire logic [mla_pkg::N_IO-1:0] io_pin,
    input wire logic [mla_pkg::N_EXT-1:0] ext_mc_in,
    input wire mla_pkg::mla_gclk_cfg_t [mla_pkg::N_GCLK-1:0] gclk_cfg,
    input wire mla_pkg::mla_mc_cfg_t [mla_pkg::N_MC-1:0] mc_cfg,
    input wire mla_pkg::mla_pia_cfg_t [mla_pkg::N_PIA-1:0] pia_cfg,
    output logic [mla_pkg::N_MC-1:0] mc_out,
    output logic [1:0] global_oe,
    output logic [mla_pkg::N_MC-1:0][mla_pkg::DELAY_W-1:0] mc_delay_ns
);

    localparam int NM = mla_pkg::N_MC;
    localparam int NP = mla_pkg::N_PT;
    localparam int AW = mla_pkg::ARR_W;

    function automatic logic [NP-1:0] route_mask(input mla_pkg::mla_mc_cfg_t c,
                                                 input mla_pkg::mla_pt_route_t r);
        logic [NP-1:0] m;
        m = '0;
        for (int j = 0; j < NP; j++) begin
            m[j] = (c.pt[j].route == r);
        end
        return m;
    endfunction : route_mask

    function automatic logic pt_eval(input mla_pkg::mla_pt_cfg_t p, input logic [AW-1:0] a);
        return (&(~p.use_true | a)) & (&(~p.use_comp | ~a));
    endfunction : pt_eval

    function automatic logic ff_step(input mla_pkg::mla_ff_type_t t, input logic q,
                                     input logic d, input logic aux);
        logic f;
        f = q;
        unique case (t)
            mla_pkg::FF_D: f = d;
            mla_pkg::FF_T: f = q ^ d;
            mla_pkg::FF_JK: f = (d & ~q) | (~aux & q);
            mla_pkg::FF_SR: f = d ? 1'b1 : (aux ? 1'b0 : q);
        endcase
        return f;
    endfunction : ff_step

    // Register state
    logic [mla_pkg::N_DED-1:0] ded_m1_r;
    logic [mla_pkg::N_DED-1:0] ded_s_r;
    logic [mla_pkg::N_IO-1:0] io_m1_r;
    logic [mla_pkg::N_IO-1:0] io_s_r;
    logic [mla_pkg::N_GCLK-1:0] gclk_prev_r;
    logic [mla_pkg::N_PIA-1:0] pia_r;
    logic [NM-1:0] mc_r;
    logic [NM-1:0] aclk_prev_r;
    logic [NM-1:0][mla_pkg::DELAY_W-1:0] delay_r;
    logic [1:0] oe_r;
    logic [31:0] ctrl_r;
    logic [mla_pkg::N_IO-1:0] io_sw_r;
    logic wr_pend_r;
    logic [7:0] wr_addr_r;
    logic [31:0] hrdata_r;
    logic hreadyout_r;
    logic hresp_r;

    // Bus decode
    wire addr_phase = hsel & hready & htrans[1];
    wire rd_req = addr_phase & ~hwrite;
    wire wr_ctrl = wr_pend_r & (wr_addr_r == mla_pkg::OFF_CTRL);
    wire wr_io_sw = wr_pend_r & (wr_addr_r == mla_pkg::OFF_IO_SW);
    wire [31:0] ctrl_nxt = wr_ctrl ? hwdata : ctrl_r;
    wire [mla_pkg::N_IO-1:0] io_sw_nxt = wr_io_sw ? hwdata[mla_pkg::N_IO-1:0] : io_sw_r;
    wire [7:0] rd_addr = haddr[7:0];
    wire rd_hit_ctrl = (haddr[31:8] == 24'h000000) & (rd_addr == mla_pkg::OFF_CTRL);
    wire rd_hit_io = (haddr[31:8] == 24'h000000) & (rd_addr == mla_pkg::OFF_IO_SW);
    wire rd_hit_mc = (haddr[31:8] == 24'h000000) & (rd_addr == mla_pkg::OFF_MC_OUT);
    wire rd_hit_ded = (haddr[31:8] == 24'h000000) & (rd_addr == mla_pkg::OFF_DED_IN);
    wire [31:0] rd_data = rd_hit_ctrl ? {31'h0000_0000, ctrl_nxt[mla_pkg::CTRL_IO_SW_SEL_BIT]} :
                          rd_hit_io ? {16'h0000, io_sw_nxt} :
                          rd_hit_mc ? {16'h0000, mc_r} :
                          rd_hit_ded ? {28'h000_0000, ded_s_r} : 32'h0000_0000;

    // Pin sources
    wire io_sw_sel = ctrl_r[mla_pkg::CTRL_IO_SW_SEL_BIT];
    wire [mla_pkg::N_IO-1:0] io_in = io_sw_sel ? io_sw_r : io_s_r;
    wire gclr_active = ~ded_s_r[mla_pkg::DED_GCLR_LOW];
    wire pin_a = ded_s_r[mla_pkg::DED_GCLK_A];
    wire pin_b = ded_s_r[mla_pkg::DED_GCLK_B];

    // Global clocks and their rising edges
    logic [mla_pkg::N_GCLK-1:0] gclk;
    logic [mla_pkg::N_GCLK-1:0] gclk_rise;
    genvar g;
    generate
        for (g = 0; g < mla_pkg::N_GCLK; g++) begin : g_gclk
            if (ENHANCED) begin : g_enh
                assign gclk[g] = (gclk_cfg[g].pin_b_sel ? pin_b : pin_a) ^ gclk_cfg[g].invert;
            end else begin : g_basic
                assign gclk[g] = pin_a;
            end
            assign gclk_rise[g] = gclk[g] & ~gclk_prev_r[g];
        end
    endgenerate

    // Global interconnect: every source, any line, gated, one register stage
    wire [mla_pkg::SRC_END-1:0] src_all = {ext_mc_in, mc_r, io_in, ded_s_r};
    wire [(2 ** mla_pkg::SRC_W)-1:0] src_pad = {{mla_pkg::SRC_PAD{1'b0}}, src_all};
    logic [mla_pkg::N_PIA-1:0] pia_nxt;
    genvar l;
    generate
        for (l = 0; l < mla_pkg::N_PIA; l++) begin : g_pia
            assign pia_nxt[l] = pia_cfg[l].pass & src_pad[pia_cfg[l].src];
        end
    endgenerate

    // Shared array inputs: interconnect lines plus inverted expanders
    logic [NM-1:0] shr_exp;
    wire [AW-1:0] arr = {shr_exp, pia_r};
    wire [AW-1:0] pia_only = {{NM{1'b1}}, pia_r};
    logic [NM-1:0] lend_val;
    logic [NM-1:0] lend_used;
    logic [NM-1:0] mc_nxt;
    logic [NM-1:0] aclk_nxt;
    logic [NM-1:0][mla_pkg::DELAY_W-1:0] delay_nxt;

    genvar i;
    genvar j;
    genvar k;
    generate
        for (i = 0; i < NM; i++) begin : g_mc
            mla_pkg::mla_mc_cfg_t c;
            logic [NP-1:0] pt_val;
            logic [NP-1:0] shr_pt_val;
            logic [NP-1:0] shr_uses;
            logic [mla_pkg::MAX_SETS-1:0] brw_bits;
            logic [mla_pkg::MAX_SETS-1:0] set_used;
            logic [1:0] set_cnt;
            assign c = mc_cfg[i];

            for (j = 0; j < NP; j++) begin : g_pt
                assign pt_val[j] = pt_eval(c.pt[j], arr);
                // Expander terms see interconnect lines only, which avoids a loop
                assign shr_pt_val[j] = pt_eval('{use_true: c.pt[j].use_true & {{NM{1'b0}},
                                                 {mla_pkg::N_PIA{1'b1}}},
                                                 use_comp: c.pt[j].use_comp & {{NM{1'b0}},
                                                 {mla_pkg::N_PIA{1'b1}}},
                                                 route: c.pt[j].route}, pia_only);
                assign shr_uses[j] = (c.pt[j].route != mla_pkg::PT_SHR) &
                                     (|(c.pt[j].use_true[AW-1:mla_pkg::N_PIA] |
                                        c.pt[j].use_comp[AW-1:mla_pkg::N_PIA]));
            end

            wire [NP-1:0] m_or = route_mask(c, mla_pkg::PT_OR);
            wire [NP-1:0] m_clr = route_mask(c, mla_pkg::PT_CLR);
            wire [NP-1:0] m_prs = route_mask(c, mla_pkg::PT_PRS);
            wire [NP-1:0] m_clk = route_mask(c, mla_pkg::PT_CLK);
            wire [NP-1:0] m_ena = route_mask(c, mla_pkg::PT_ENA);
            wire [NP-1:0] m_aux = route_mask(c, mla_pkg::PT_AUX);
            wire [NP-1:0] m_shr = route_mask(c, mla_pkg::PT_SHR);
            wire [NP-1:0] m_lend = route_mask(c, mla_pkg::PT_LEND);

            assign shr_exp[i] = ~(|(shr_pt_val & m_shr));

            // Chain top never lends
            if ((i % mla_pkg::CHAIN_LEN) == mla_pkg::CHAIN_LEN - 1) begin : g_top
                assign lend_val[i] = 1'b0;
                assign lend_used[i] = 1'b0;
            end else begin : g_lend
                assign lend_val[i] = |(pt_val & m_lend);
                assign lend_used[i] = |m_lend;
            end

            // Borrow only from lower neighbours in the same chain
            for (k = 1; k <= mla_pkg::MAX_SETS; k++) begin : g_brw
                if (k <= (i % mla_pkg::CHAIN_LEN)) begin : g_ok
                    assign brw_bits[k-1] = (c.borrow_sets >= 2'(k)) & lend_val[i-k];
                    assign set_used[k-1] = (c.borrow_sets >= 2'(k)) & lend_used[i-k];
                end else begin : g_none
                    assign brw_bits[k-1] = 1'b0;
                    assign set_used[k-1] = 1'b0;
                end
            end

            assign set_cnt = 2'({1'b0, set_used[0]} + {1'b0, set_used[1]} + {1'b0, set_used[2]});
            assign delay_nxt[i] = mla_pkg::DELAY_W'(set_cnt * PEXP_DELAY_NS +
                                  ((|shr_uses) ? SEXP_DELAY_NS : 0));

            wire comb = (|(pt_val & m_or) | (|brw_bits)) ^ c.xor_inv;
            wire clr_pt = |(pt_val & m_clr);
            wire prs_pt = |(pt_val & m_prs);
            wire clk_pt = |(pt_val & m_clk);
            wire ena_pt = |(pt_val & m_ena);
            wire aux_pt = |(pt_val & m_aux);
            wire d_in = (ENHANCED && c.fast_in_en) ? io_in[i] : comb;
            wire clr = clr_pt | (c.gclr_en & gclr_active);
            logic fire;

            always_comb begin
                unique case (c.clk_mode)
                    mla_pkg::CLK_GLOBAL: fire = gclk_rise[c.gclk_sel];
                    mla_pkg::CLK_GLOBAL_ENA: fire = gclk_rise[c.gclk_sel] & ena_pt;
                    mla_pkg::CLK_ARRAY: fire = clk_pt & ~aclk_prev_r[i];
                    default: fire = 1'b0;
                endcase
            end

            assign aclk_nxt[i] = clk_pt;
            assign mc_nxt[i] = c.bypass ? comb :
                               clr ? 1'b0 :
                               prs_pt ? 1'b1 :
                               fire ? ff_step(c.ff_type, mc_r[i], d_in, aux_pt) : mc_r[i];
        end
    endgenerate

    // Synchronisers and edge history
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ded_m1_r <= 4'hF;
            ded_s_r <= 4'hF;
            io_m1_r <= mla_pkg::IO_SW_RST;
            io_s_r <= mla_pkg::IO_SW_RST;
            // Matches synced reset level, no false edge
            gclk_prev_r <= 2'h3;
            aclk_prev_r <= 16'h0000;
        end else begin
            ded_m1_r <= ded_pin;
            ded_s_r <= ded_m1_r;
            io_m1_r <= io_pin;
            io_s_r <= io_m1_r;
            gclk_prev_r <= gclk;
            aclk_prev_r <= aclk_nxt;
        end
    end

    // Interconnect stage and macrocell registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pia_r <= 36'h0_0000_0000;
            mc_r <= mla_pkg::MC_RST;
            delay_r <= '0;
            oe_r <= 2'h0;
        end else begin
            pia_r <= pia_nxt;
            mc_r <= mc_nxt;
            delay_r <= delay_nxt;
            oe_r <= ~ded_s_r[mla_pkg::DED_GCLK_B:mla_pkg::DED_OE_A];
        end
    end

    // Bus slave
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r <= mla_pkg::CTRL_RST;
            io_sw_r <= mla_pkg::IO_SW_RST;
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            hrdata_r <= 32'h0000_0000;
            hreadyout_r <= 1'b1;
            hresp_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            io_sw_r <= io_sw_nxt;
            wr_pend_r <= addr_phase & hwrite & (haddr[31:8] == 24'h000000);
            wr_addr_r <= haddr[7:0];
            hrdata_r <= rd_req ? rd_data : hrdata_r;
            hreadyout_r <= 1'b1;
            hresp_r <= 1'b0;
        end
    end

    assign hrdata = hrdata_r;
    assign hreadyout = hreadyout_r;
    assign hresp = hresp_r;
    assign mc_out = mc_r;
    assign global_oe = oe_r;
    assign mc_delay_ns = delay_r;

endmodule : mla_logic_array_block
`default_nettype wire

// ### mla_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module mla_pin_model (
    input wire logic hclk,
    input wire logic pulse,
    input wire logic [3:1] ded_lvl,
    input wire logic [mla_pkg::N_IO-1:0] io_lvl,
    output logic [mla_pkg::N_DED-1:0] ded_pin,
    output logic [mla_pkg::N_IO-1:0] io_pin
);
    logic [2:0] pulse_cnt_r = 3'h0;
    // One slow clock pin pulse per request, low between pulses
    always_ff @(posedge hclk) begin
        if (pulse)
            pulse_cnt_r <= 3'h7;
        else if (pulse_cnt_r != 3'h0)
            pulse_cnt_r <= pulse_cnt_r - 3'h1;
    end
    assign ded_pin = {ded_lvl, pulse_cnt_r >= 3'h4};
    assign io_pin = io_lvl;
endmodule : mla_pin_model
`default_nettype wire

// ### mla_sva.sv
`timescale 1ns/1ps
`default_nettype none
module mla_sva #(
    parameter int SEXP_DELAY_NS = 1,
    parameter int PEXP_DELAY_NS = 1
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [mla_pkg::N_DED-1:0] ded_pin,
    input wire mla_pkg::mla_mc_cfg_t [mla_pkg::N_MC-1:0] mc_cfg,
    input wire logic [mla_pkg::N_MC-1:0] mc_out,
    input wire logic [1:0] global_oe,
    input wire logic [mla_pkg::N_MC-1:0][mla_pkg::DELAY_W-1:0] mc_delay_ns
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic [2:0] up_cnt_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            up_cnt_r <= 3'h0;
        else if (up_cnt_r != 3'h7)
            up_cnt_r <= up_cnt_r + 3'h1;
    end
    a_reset_low: assert property ($rose(hresetn) |-> mc_out == '0)
        else $error("macrocell not low after reset");
    a_oe_follow: assert property (up_cnt_r >= 3'h4 |-> global_oe == ~$past(ded_pin[3:2], 3))
        else $error("output enable does not follow pins");
    for (genvar i = 0; i < mla_pkg::N_MC; i++) begin : g_mc
        logic [mla_pkg::N_PT-1:0] live;
        logic [mla_pkg::N_PT-1:0] ctl;
        logic quiet;
        for (genvar k = 0; k < mla_pkg::N_PT; k++) begin : g_pt
            assign live[k] = mc_cfg[i].pt[k].route != mla_pkg::PT_OFF;
            assign ctl[k] = mc_cfg[i].pt[k].route inside {mla_pkg::PT_ENA, mla_pkg::PT_CLR,
                mla_pkg::PT_PRS};
        end
        assign quiet = (live == '0) && (mc_cfg[i].borrow_sets == 2'h0) && !mc_cfg[i].gclr_en
            && !mc_cfg[i].fast_in_en;
        a_quiet_comb: assert property (up_cnt_r >= 3'h2 && quiet && mc_cfg[i].bypass
            |-> mc_out[i] == mc_cfg[i].xor_inv)
            else $error("idle bypassed macrocell wrong");
        a_quiet_reg: assert property (quiet && !mc_cfg[i].bypass
            && !mc_cfg[i].xor_inv && mc_cfg[i].ff_type == mla_pkg::FF_D |-> !mc_out[i])
            else $error("idle register not low");
        a_ena_hold: assert property (!mc_cfg[i].bypass && ctl == '0
            && !mc_cfg[i].gclr_en
            && mc_cfg[i].clk_mode == mla_pkg::CLK_GLOBAL_ENA |=> $stable(mc_out[i]))
            else $error("register loaded without enable");
        a_clear_pin: assert property (
            (mc_cfg[i].gclr_en && !mc_cfg[i].bypass && !ded_pin[1]) [*4] |-> !mc_out[i])
            else $error("global clear ignored");
        a_chain_bottom: assert property ((i % mla_pkg::CHAIN_LEN) != 0
            || mc_delay_ns[i] <= SEXP_DELAY_NS)
            else $error("chain bottom borrowed");
        a_delay_max: assert property (
            mc_delay_ns[i] <= 3 * PEXP_DELAY_NS + SEXP_DELAY_NS)
            else $error("more than three borrowed sets");
    end
    c_oe_active: cover property (global_oe != 2'h0);
    c_clear: cover property ($fell(ded_pin[1]));
    c_out_set: cover property (mc_out != '0);
endmodule : mla_sva
`default_nettype wire

// ### mla_logic_array_block_bench.sv
`timescale 1ns/1ps
`default_nettype none
module mla_logic_array_block_bench;
    localparam int SEXP = 1;
    localparam int PEXP = 2;
    logic hclk, hresetn, hsel, hwrite, hresp, hreadyout, pulse;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans, global_oe;
    logic [2:0] hsize;
    logic [3:1] ded_lvl;
    logic [mla_pkg::N_DED-1:0] ded_pin;
    logic [mla_pkg::N_IO-1:0] io_pin, io_lvl, ext_mc_in, mc_out;
    mla_pkg::mla_gclk_cfg_t [mla_pkg::N_GCLK-1:0] gclk_cfg;
    mla_pkg::mla_mc_cfg_t [mla_pkg::N_MC-1:0] mc_cfg;
    mla_pkg::mla_pia_cfg_t [mla_pkg::N_PIA-1:0] pia_cfg;
    logic [mla_pkg::N_MC-1:0][mla_pkg::DELAY_W-1:0] mc_delay_ns;
    int fail_count = 0;
    int cmp_count = 0;
    mla_logic_array_block #(.SEXP_DELAY_NS(SEXP), .PEXP_DELAY_NS(PEXP)) dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .ded_pin(ded_pin), .io_pin(io_pin),
        .ext_mc_in(ext_mc_in), .gclk_cfg(gclk_cfg), .mc_cfg(mc_cfg), .pia_cfg(pia_cfg),
        .mc_out(mc_out), .global_oe(global_oe), .mc_delay_ns(mc_delay_ns));
    mla_pin_model u_pins (.hclk(hclk), .pulse(pulse), .ded_lvl(ded_lvl), .io_lvl(io_lvl),
        .ded_pin(ded_pin), .io_pin(io_pin));
    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : give_verdict
    task automatic do_reset();
        hresetn <= 1'b0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
    endtask : do_reset
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask : ahb
    task automatic clk_pulse();
        pulse <= 1'b1;
        @(posedge hclk);
        pulse <= 1'b0;
        repeat (12) @(posedge hclk);
    endtask : clk_pulse
    task automatic t_reset();
        logic [31:0] rd;
        check("mc_out at reset", 32'(mc_out), 32'h0);
        ahb(1'b0, mla_pkg::OFF_CTRL, 32'h0, rd);
        check("ctrl reset", rd, mla_pkg::CTRL_RST);
        ahb(1'b0, 8'h40, 32'h0, rd);
        check("unmapped read", rd, 32'h0);
        ded_lvl[2] <= 1'b0;
        repeat (6) @(posedge hclk);
        check("global_oe", 32'(global_oe), 32'h1);
        ded_lvl <= 3'h7;
        $display("test reset done");
    endtask : t_reset
    task automatic t_comb();
        mla_pkg::mla_mc_cfg_t [mla_pkg::N_MC-1:0] m;
        mla_pkg::mla_pia_cfg_t [mla_pkg::N_PIA-1:0] q;
        logic [31:0] rd;
        m = '0;
        q = '0;
        for (int j = 0; j < 3; j++) q[j] = {j != 2, 6'(mla_pkg::SRC_IO + j)};
        m[0].pt[0].use_true[1:0] = 2'h3;
        m[1].pt[0].use_true[2] = 1'b1;
        m[2].pt[0].use_comp[0] = 1'b1;
        for (int i = 0; i < 3; i++) m[i].pt[0].route = mla_pkg::PT_OR;
        m[4].pt[0].use_true[0] = 1'b1;
        m[4].pt[0].route = mla_pkg::PT_LEND;
        m[5].borrow_sets = 2'h1;
        for (int i = 0; i < 16; i++) m[i].bypass = (i != 3) && (i != 4) && (i < 6 || i > 7);
        m[9].xor_inv = 1'b1;
        m[10].pt[0].use_true[1] = 1'b1;
        m[10].pt[0].route = mla_pkg::PT_SHR;
        m[11].pt[0].use_true[mla_pkg::N_PIA + 10] = 1'b1;
        m[11].pt[0].route = mla_pkg::PT_OR;
        mc_cfg <= m;
        pia_cfg <= q;
        do_reset();
        for (int p = 0; p < 4; p++) begin
            io_lvl <= 16'h0004 | 16'(p);
            repeat (8) @(posedge hclk);
            check("comb out", 32'(mc_out & 16'h0A27),
                {20'h0, !p[1], 1'b0, 1'b1, 3'h0, p[0], 2'h0, !p[0], 1'b0, p[0] & p[1]});
        end
        check("delay mc5", 32'(mc_delay_ns[5]), 32'(PEXP));
        check("delay mc11", 32'(mc_delay_ns[11]), 32'(SEXP));
        ahb(1'b1, mla_pkg::OFF_CTRL, 32'h1, rd);
        ahb(1'b1, mla_pkg::OFF_IO_SW, 32'h7, rd);
        io_lvl <= 16'h0;
        repeat (8) @(posedge hclk);
        ahb(1'b0, mla_pkg::OFF_MC_OUT, 32'h0, rd);
        check("mc_out read", rd, 32'h0000_0221);
        ahb(1'b0, mla_pkg::OFF_IO_SW, 32'h0, rd);
        check("io_sw read", rd, 32'h7);
        $display("test comb done");
    endtask : t_comb
    task automatic t_reg();
        mla_pkg::mla_mc_cfg_t [mla_pkg::N_MC-1:0] m;
        mla_pkg::mla_pia_cfg_t [mla_pkg::N_PIA-1:0] q;
        m = '0;
        q = '0;
        for (int j = 0; j < 2; j++) q[j] = {1'b1, 6'(mla_pkg::SRC_IO + j)};
        for (int i = 3; i < 8; i++) begin
            m[i].pt[0].use_true[0] = 1'b1;
            m[i].pt[0].route = mla_pkg::PT_OR;
        end
        m[3].gclr_en = 1'b1;
        m[4].pt[0].use_true[1:0] = 2'h2;
        m[4].pt[0].route = mla_pkg::PT_PRS;
        m[6].clk_mode = mla_pkg::CLK_GLOBAL_ENA;
        m[7].ff_type = mla_pkg::FF_T;
        m[0].fast_in_en = 1'b1;
        m[6].pt[1].use_comp[1] = 1'b1;
        m[6].pt[1].route = mla_pkg::PT_ENA;
        m[8] = m[5];
        m[8].clk_mode = mla_pkg::CLK_GLOBAL_ENA;
        m[9].pt[0].use_comp[0] = 1'b1;
        m[9].pt[0].route = mla_pkg::PT_OR;
        m[9].pt[1].use_true[1] = 1'b1;
        m[9].pt[1].route = mla_pkg::PT_CLK;
        m[9].clk_mode = mla_pkg::CLK_ARRAY;
        m[10] = m[5];
        m[10].ff_type = mla_pkg::FF_JK;
        m[10].pt[1] = m[5].pt[0];
        m[10].pt[1].route = mla_pkg::PT_AUX;
        mc_cfg <= m;
        pia_cfg <= q;
        do_reset();
        io_lvl <= 16'h0001;
        repeat (8) @(posedge hclk);
        clk_pulse();
        check("first clock", 32'(mc_out), 32'h0000_04E9);
        clk_pulse();
        check("second clock", 32'(mc_out), 32'h0000_0069);
        io_lvl <= 16'h0002;
        repeat (8) @(posedge hclk);
        check("preset", 32'(mc_out), 32'h0000_0279);
        ded_lvl[1] <= 1'b0;
        repeat (8) @(posedge hclk);
        check("global clear", 32'(mc_out), 32'h0000_0271);
        ded_lvl <= 3'h7;
        $display("test reg done");
    endtask : t_reg
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        pulse = 1'b0;
        ded_lvl = 3'h7;
        io_lvl = 16'h0;
        ext_mc_in = 16'hA5A5;
        gclk_cfg = '0;
        mc_cfg = '0;
        pia_cfg = '0;
        do_reset();
        t_reset();
        t_comb();
        t_reg();
        give_verdict();
    end
    initial begin
        repeat (5000) @(posedge hclk);
        fail_count++;
        give_verdict();
    end
endmodule : mla_logic_array_block_bench
bind mla_logic_array_block mla_sva #(
    .SEXP_DELAY_NS(SEXP_DELAY_NS),
    .PEXP_DELAY_NS(PEXP_DELAY_NS)
) u_sva (
    .hclk(hclk), .hresetn(hresetn), .ded_pin(ded_pin), .mc_cfg(mc_cfg), .mc_out(mc_out),
    .global_oe(global_oe), .mc_delay_ns(mc_delay_ns));
`default_nettype wire
